/* File: rtl/ivp_top.sv */
// ivp_top: interrupt vector placement control with an AXI4-Lite register slave
//
// Overview of operation
// - With vector_select clear the vector table sits at the start of program flash.
// - With vector_select set the table moves to the boot section start given by the size fuses.
// - A new select value is taken only while change enable is set.
// - Change enable clears itself four cycles after being set, or when select is written.
// - Interrupts are blocked from the cycle change enable sets until the instruction after the select write completes.
// - Without a select write interrupts stay blocked exactly five cycles: the cycle of the write plus the four cycles of change enable.
// - The automatic blocking leaves the global interrupt enable flag alone.
// - Vectors in boot with the application-side lock programmed suppress interrupts while running in the application area.
// - Vectors in application with the boot-side lock programmed suppress interrupts while running in boot.
// - Boot reset off, 2 Kbyte boot, vectors moved: reset at zero, vectors from 1C02 to 1C28.
// - Boot reset on with 2 Kbyte boot: execution starts at 1C00.
// - Reset address is zero or the boot address; the table starts two words above the chosen base.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ivp_top
  import ivp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // fuses and lock bits
  input  wire logic        boot_reset_fuse,
  input  wire logic [1:0]  boot_size_fuses,
  input  wire logic        app_side_boot_lock,
  input  wire logic        boot_side_boot_lock,
  // core side
  input  wire logic [12:0] exec_pc,
  input  wire logic [4:0]  vec_index,
  input  wire logic        insn_done,
  output logic [12:0]      reset_addr,
  output logic [12:0]      vec_addr,
  output logic             irq_allow,
  output logic             ext_irq0_enable,
  output logic             ext_irq1_enable,
  output logic             ext_irq2_enable
);

  typedef struct packed {
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        vec_sel;
    logic [2:0]  irq_en;     // {irq1, irq0, irq2}
    logic [12:0] reset_addr;
    logic [12:0] vec_addr;
  } ivp_top_s;

  ivp_top_s st_r;
  ivp_top_s st_nxt;

  logic        chg_en;
  logic        win_block;
  logic        open_req;
  logic        sel_write;
  logic        wr_fire;
  logic [12:0] table_base;
  logic [12:0] reset_addr_c;
  logic [12:0] vec_addr_c;
  logic [7:0]  gic_view;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register view assembled in one place, used by reads only; writes take the fields straight from the data
  function automatic logic [7:0] gic_pack(input logic [2:0] en, input logic sel,
                                          input logic chg);
    logic [7:0] v;
    v = 8'h00;
    v[IVP_BIT_IRQ1] = en[2];
    v[IVP_BIT_IRQ0] = en[1];
    v[IVP_BIT_IRQ2] = en[0];
    v[IVP_BIT_SEL]  = sel;
    v[IVP_BIT_CHG]  = chg;
    gic_pack = v & IVP_GIC_RW_MASK;
  endfunction

  assign gic_view = gic_pack(st_r.irq_en, st_r.vec_sel, chg_en);

  // ----------------------------------------------------------------
  // write decode: a write commits once address and data are both held
  // ----------------------------------------------------------------
  assign wr_fire   = st_r.aw_full && st_r.w_full && !st_r.bvalid;
  // only byte lane 0 carries the control register
  assign open_req  = wr_fire && (st_r.aw_addr == IVP_ADDR_GIC) && st_r.w_strb[0]
                   && st_r.w_data[IVP_BIT_CHG];
  assign sel_write = wr_fire && (st_r.aw_addr == IVP_ADDR_GIC) && st_r.w_strb[0]
                   && !st_r.w_data[IVP_BIT_CHG];

  // ----------------------------------------------------------------
  // change window and interrupt gating
  // ----------------------------------------------------------------
  ivp_window u_window (
    .clk       (clk),
    .rst       (rst),
    .open_req  (open_req),
    .sel_write (sel_write),
    .insn_done (insn_done),
    .chg_en    (chg_en),
    .irq_block (win_block)
  );

  ivp_gate u_gate (
    .vec_sel             (st_r.vec_sel),
    .boot_reset_fuse     (boot_reset_fuse),
    .boot_size_fuses     (boot_size_fuses),
    .app_side_boot_lock  (app_side_boot_lock),
    .boot_side_boot_lock (boot_side_boot_lock),
    .exec_pc             (exec_pc),
    .vec_index           (vec_index),
    .window_block        (win_block),
    .reset_addr          (reset_addr_c),
    .table_base          (table_base),
    .vec_addr            (vec_addr_c),
    .irq_allow           (irq_allow)
  );

  // ----------------------------------------------------------------
  // next-state: bus channels, register updates, registered addresses
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // accept address and data in either order, one of each at a time
    if (s_axi_awvalid && !st_r.aw_full) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_full) begin
      st_nxt.w_full = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = IVP_RESP_OKAY;
      case (st_r.aw_addr)
        IVP_ADDR_GIC: begin
          if (st_r.w_strb[0]) begin
            st_nxt.irq_en = {st_r.w_data[IVP_BIT_IRQ1], st_r.w_data[IVP_BIT_IRQ0],
                             st_r.w_data[IVP_BIT_IRQ2]};
            // select only moves inside the window; stray writes leave it alone
            if (chg_en && !st_r.w_data[IVP_BIT_CHG]) begin
              st_nxt.vec_sel = st_r.w_data[IVP_BIT_SEL];
            end
          end
        end
        IVP_ADDR_STATUS, IVP_ADDR_FUSE, IVP_ADDR_BASE: begin
          st_nxt.bresp = IVP_RESP_OKAY;   // read-only, writes ignored
        end
        default: begin
          st_nxt.bresp = IVP_RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = IVP_RESP_OKAY;
      case (s_axi_araddr)
        IVP_ADDR_GIC:    st_nxt.rdata = {24'h00_0000, gic_view};
        IVP_ADDR_STATUS: st_nxt.rdata = {29'h0000_0000, irq_allow, win_block, chg_en};
        IVP_ADDR_FUSE:   st_nxt.rdata = {27'h000_0000, boot_side_boot_lock,
                                         app_side_boot_lock, boot_size_fuses,
                                         boot_reset_fuse};
        IVP_ADDR_BASE:   st_nxt.rdata = {19'h0_0000, table_base};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = IVP_RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.reset_addr = reset_addr_c;
    st_nxt.vec_addr   = vec_addr_c;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready   = !st_r.aw_full;
  assign s_axi_wready    = !st_r.w_full;
  assign s_axi_bvalid    = st_r.bvalid;
  assign s_axi_bresp     = st_r.bresp;
  assign s_axi_arready   = !st_r.rvalid;
  assign s_axi_rvalid    = st_r.rvalid;
  assign s_axi_rdata     = st_r.rdata;
  assign s_axi_rresp     = st_r.rresp;
  // addresses are a cycle behind fuse or select changes
  assign reset_addr      = st_r.reset_addr;
  assign vec_addr        = st_r.vec_addr;
  assign ext_irq1_enable = st_r.irq_en[2];
  assign ext_irq0_enable = st_r.irq_en[1];
  assign ext_irq2_enable = st_r.irq_en[0];

endmodule

/* File: inc/ivp_pkg.sv */
// ivp_pkg: register map, field positions, fuse decode and timing counts for vector placement
package ivp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IVP_ADDR_GIC     = 8'h00;   // general_interrupt_control
  localparam logic [7:0]  IVP_ADDR_STATUS  = 8'h04;   // block state, read only
  localparam logic [7:0]  IVP_ADDR_FUSE    = 8'h08;   // fuse and lock view, read only
  localparam logic [7:0]  IVP_ADDR_BASE    = 8'h0C;   // vector table base, read only
  localparam logic [7:0]  IVP_GIC_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // field positions of general_interrupt_control
  // ----------------------------------------------------------------
  localparam int IVP_BIT_CHG  = 0;   // vector_change_enable
  localparam int IVP_BIT_SEL  = 1;   // vector_select
  localparam int IVP_BIT_IRQ2 = 5;   // ext_irq2_enable
  localparam int IVP_BIT_IRQ0 = 6;   // ext_irq0_enable
  localparam int IVP_BIT_IRQ1 = 7;   // ext_irq1_enable
  localparam logic [7:0] IVP_GIC_RW_MASK = 8'hE3;

  // ----------------------------------------------------------------
  // timing: the change window lasts four system cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] IVP_WINDOW_CYCLES = 3'h4;

  // ----------------------------------------------------------------
  // flash word addresses
  // ----------------------------------------------------------------
  localparam logic [12:0] IVP_RESET_APP   = 13'h0000;
  localparam logic [12:0] IVP_VEC_OFFSET  = 13'h0002;
  // boot reset address per boot_size_fuses value 00,01,10,11
  localparam logic [12:0] IVP_BOOT_BASE_0 = 13'h1C00;   // 2 Kbyte boot section
  localparam logic [12:0] IVP_BOOT_BASE_1 = 13'h1E00;
  localparam logic [12:0] IVP_BOOT_BASE_2 = 13'h1F00;
  localparam logic [12:0] IVP_BOOT_BASE_3 = 13'h1F80;

  // axi response codes
  localparam logic [1:0] IVP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] IVP_RESP_SLVERR = 2'h2;

  // boot section start from the size fuses
  function automatic logic [12:0] ivp_boot_base(input logic [1:0] sz);
    case (sz)
      2'h0:    ivp_boot_base = IVP_BOOT_BASE_0;
      2'h1:    ivp_boot_base = IVP_BOOT_BASE_1;
      2'h2:    ivp_boot_base = IVP_BOOT_BASE_2;
      default: ivp_boot_base = IVP_BOOT_BASE_3;
    endcase
  endfunction

endpackage

/* File: rtl/ivp_window.sv */
// ivp_window: timed change window for the vector select bit and interrupt blocking
`timescale 1ns/1ps
module ivp_window
  import ivp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic open_req,     // software wrote change enable to one
  input  wire logic sel_write,    // software wrote the register with change enable zero
  input  wire logic insn_done,    // core finished an instruction
  output logic      chg_en,       // change enable bit as seen by software
  output logic      irq_block     // interrupt acceptance blocked
);

  typedef struct packed {
    logic       chg;
    logic [2:0] cnt;
    logic       tail;     // waiting for the instruction after the select write
  } ivp_win_s;

  ivp_win_s st_r;
  ivp_win_s st_nxt;

  // ----------------------------------------------------------------
  // window sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // the instruction after the select write must complete, not the write itself;
    // cleared first so a select write in the same cycle keeps the block set
    if (st_r.tail && insn_done) begin
      st_nxt.tail = 1'b0;
    end
    if (st_r.chg) begin
      st_nxt.cnt = st_r.cnt - 3'h1;
      if (sel_write) begin
        st_nxt.chg  = 1'b0;
        st_nxt.tail = 1'b1;
        st_nxt.cnt  = 3'h0;
      end else if (st_r.cnt == 3'h1) begin
        st_nxt.chg = 1'b0;
      end
    end
    // a fresh enable restarts the count
    if (open_req) begin
      st_nxt.chg = 1'b1;
      st_nxt.cnt = IVP_WINDOW_CYCLES;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chg_en = st_r.chg;
  // blocked in the cycle the enable lands, so look at the request too
  assign irq_block = open_req | st_r.chg | st_r.tail;

endmodule

/* File: rtl/ivp_gate.sv */
// ivp_gate: vector addressing and interrupt suppression from placement and lock bits
`timescale 1ns/1ps
module ivp_gate
  import ivp_pkg::*;
(
  input  wire logic        vec_sel,
  input  wire logic        boot_reset_fuse,     // 1 unprogrammed
  input  wire logic [1:0]  boot_size_fuses,
  input  wire logic        app_side_boot_lock,  // 0 programmed
  input  wire logic        boot_side_boot_lock, // 0 programmed
  input  wire logic [12:0] exec_pc,
  input  wire logic [4:0]  vec_index,
  input  wire logic        window_block,
  output logic [12:0]      reset_addr,
  output logic [12:0]      table_base,
  output logic [12:0]      vec_addr,
  output logic             irq_allow
);

  logic [12:0] boot_base;
  logic        in_boot;
  logic        lock_block;

  // ----------------------------------------------------------------
  // address arithmetic
  // ----------------------------------------------------------------
  assign boot_base  = ivp_boot_base(boot_size_fuses);
  assign reset_addr = boot_reset_fuse ? IVP_RESET_APP : boot_base;
  // table base is two words above zero or above the boot section start
  assign table_base = (vec_sel ? boot_base : IVP_RESET_APP) + IVP_VEC_OFFSET;
  assign vec_addr   = table_base + {7'h00, vec_index, 1'b0};

  // ----------------------------------------------------------------
  // suppression; the global enable flag is never touched here
  // ----------------------------------------------------------------
  assign in_boot    = exec_pc >= boot_base;
  assign lock_block = (vec_sel && !app_side_boot_lock && !in_boot)
                    | (!vec_sel && !boot_side_boot_lock && in_boot);
  assign irq_allow  = !(window_block | lock_block);

endmodule

/* File: verification/ivp_top_monitor.sv */
// ivp_top_monitor: port assertions for vector placement
`timescale 1ns/1ps
module ivp_top_monitor
  import ivp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        boot_reset_fuse,
  input wire logic [1:0]  boot_size_fuses,
  input wire logic        app_side_boot_lock,
  input wire logic        boot_side_boot_lock,
  input wire logic [12:0] exec_pc,
  input wire logic [4:0]  vec_index,
  input wire logic        insn_done,
  input wire logic [12:0] reset_addr,
  input wire logic [12:0] vec_addr,
  input wire logic        irq_allow
);
  // ------------
  // helpers
  // ------------
  logic ctl_r;   // pending write targets the control register
  logic open_r;  // pending write sets change enable
  logic free;    // no lock bit programmed
  logic vb;      // vectors in boot space: every boot base is at or above 1C00
  assign free = app_side_boot_lock & boot_side_boot_lock;
  assign vb   = vec_addr >= IVP_BOOT_BASE_0;
  // latched at the channel handshakes so the response edge still sees them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r  <= 1'b0;
      open_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) ctl_r <= s_axi_awaddr == IVP_ADDR_GIC;
      if (s_axi_wvalid && s_axi_wready) open_r <= s_axi_wdata[0] & s_axi_wstrb[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------------
  // assertions
  // ------------
  a_reset_app: assert property (
    !$past(rst) && $past(boot_reset_fuse) |-> reset_addr == IVP_RESET_APP)
    else $error("reset address not zero");
  a_reset_boot: assert property (
    !$past(rst) && !$past(boot_reset_fuse) && $past(boot_size_fuses) == 2'h0
    |-> reset_addr == IVP_BOOT_BASE_0) else $error("boot reset address wrong");
  a_vec_slot: assert property (
    !$past(rst) |-> (vec_addr - {$past(vec_index), 1'b0}) inside {13'h0002, 13'h1C02,
    13'h1E02, 13'h1F02, 13'h1F82}) else $error("vector slot address wrong");
  a_block_start: assert property (
    $rose(s_axi_bvalid) && ctl_r && open_r |-> !irq_allow [*3])
    else $error("interrupts not blocked by change enable");
  a_block_ends: assert property (
    $rose(s_axi_bvalid) && ctl_r && open_r ##1 (!s_axi_wvalid && free) [*6] |-> irq_allow)
    else $error("interrupts still blocked after the window");
  a_sel_block: assert property (
    free && vb != $past(vb) && !$past(insn_done, 2) && !$past(insn_done) && !insn_done
    |-> !irq_allow) else $error("interrupts free before the next instruction");
  a_lock_app: assert property (
    !app_side_boot_lock && boot_size_fuses == 2'h0 && vb && !s_axi_bvalid
    && exec_pc < IVP_BOOT_BASE_0 |-> !irq_allow) else $error("app lock ignored");
  a_lock_boot: assert property (
    !boot_side_boot_lock && boot_size_fuses == 2'h0 && !vb && !s_axi_bvalid
    && exec_pc >= IVP_BOOT_BASE_0 |-> !irq_allow) else $error("boot lock ignored");
endmodule

bind ivp_top ivp_top_monitor u_mon (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .boot_reset_fuse(boot_reset_fuse),
  .boot_size_fuses(boot_size_fuses), .app_side_boot_lock(app_side_boot_lock),
  .boot_side_boot_lock(boot_side_boot_lock), .exec_pc(exec_pc), .vec_index(vec_index),
  .insn_done(insn_done), .reset_addr(reset_addr), .vec_addr(vec_addr), .irq_allow(irq_allow));

/* File: verification/ivp_core_model.sv */
// ivp_core_model: stand-in for the core fetch and instruction completion logic
`timescale 1ns/1ps
module ivp_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  pace,      // cycles between finished instructions, 0 stalls
  input  wire logic [12:0] pc_base,   // start of the region the program runs in
  input  wire logic [4:0]  want_idx,  // vector the core looks up
  output logic [12:0]      exec_pc,
  output logic [4:0]       vec_index,
  output logic             insn_done
);
  logic [3:0] gap_r;
  logic [3:0] step_r;
  // a stall is the slow case: the block must hold its select block until a pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r     <= 4'h0;
      step_r    <= 4'h0;
      insn_done <= 1'b0;
    end else begin
      insn_done <= (pace != 4'h0) && (gap_r == 4'h0);
      gap_r     <= (gap_r == 4'h0) ? pace : gap_r - 4'h1;
      step_r    <= step_r + 4'h1;
    end
  end
  // the pc wanders within sixteen words so region tests see a moving address
  assign exec_pc   = pc_base + {9'h000, step_r};
  assign vec_index = want_idx;
endmodule

/* File: verification/ivp_top_tb_top.sv */
// ivp_top_tb_top: self-checking bench for vector placement control
`timescale 1ns/1ps
module ivp_top_tb_top
  import ivp_pkg::*;
  ;
  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, boot_reset_fuse, app_side_boot_lock, boot_side_boot_lock;
  logic        insn_done, irq_allow, ext_irq0_enable, ext_irq1_enable, ext_irq2_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, e;
  logic [3:0]  s_axi_wstrb, pace;
  logic [1:0]  s_axi_bresp, s_axi_rresp, boot_size_fuses;
  logic [12:0] exec_pc, reset_addr, vec_addr, pc_base;
  logic [4:0]  vec_index, want_idx;
  logic [12:0] bb [4] = '{IVP_BOOT_BASE_0, IVP_BOOT_BASE_1, IVP_BOOT_BASE_2, IVP_BOOT_BASE_3};
  int          bad_count = 0;
  int          n_checks = 0;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];

  ivp_top i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .boot_reset_fuse(boot_reset_fuse),
    .boot_size_fuses(boot_size_fuses), .app_side_boot_lock(app_side_boot_lock),
    .boot_side_boot_lock(boot_side_boot_lock), .exec_pc(exec_pc), .vec_index(vec_index),
    .insn_done(insn_done), .reset_addr(reset_addr), .vec_addr(vec_addr),
    .irq_allow(irq_allow), .ext_irq0_enable(ext_irq0_enable),
    .ext_irq1_enable(ext_irq1_enable), .ext_irq2_enable(ext_irq2_enable));
  ivp_core_model i_core (.clk(clk), .rst(rst), .pace(pace), .pc_base(pc_base),
    .want_idx(want_idx), .exec_pc(exec_pc), .vec_index(vec_index), .insn_done(insn_done));

  // ------------
  // tasks
  // ------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb, da, dw;
    hb = 1'b0;
    da = 1'b0;
    dw = 1'b0;
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!hb) begin
      @(negedge clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      @(posedge clk);
      da = da | ha;
      dw = dw | hw;
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      // ready is raised late so a chained write never touches it twice in one step
      if (hb) s_axi_bready <= 1'b0;
      else if (da && dw) s_axi_bready <= 1'b1;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    hr = 1'b0;
    rq.push_back({er, ed});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!hr) begin
      @(negedge clk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      @(posedge clk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (ha) s_axi_rready <= 1'b1;
      if (hr) s_axi_rready <= 1'b0;
    end
  endtask
  // port checks look in the low phase, where everything has settled
  task automatic port(input int n, input string nm, input logic [31:0] exp);
    repeat (n) @(posedge clk);
    @(negedge clk);
    if (nm == "irq") chk(nm, exp, {31'h0, irq_allow});
    else if (nm == "vec") chk(nm, exp, {19'h0, vec_addr});
    else chk(nm, exp, {19'h0, reset_addr});
    @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------
  // stimulus and response matching
  // ------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // each bus answer is matched with the oldest note left by the driver
  always @(negedge clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      chk("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      chk("rdata", rq[0][31:0], s_axi_rdata);
      chk("rresp", {30'h0, rq[0][33:32]}, {30'h0, s_axi_rresp});
      void'(rq.pop_front());
    end
  end
  // the run needs well under a thousand cycles; twenty thousand means a hang
  initial begin
    #500000;
    bad_count++;
    close_out();
  end
  initial begin
    {rst, boot_reset_fuse, app_side_boot_lock, boot_side_boot_lock} = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_0000;
    {boot_size_fuses, want_idx, pace, pc_base} = {2'h0, 5'h00, 4'h3, 13'h0100};
    e = $urandom(51);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(IVP_ADDR_GIC, 32'h0000_0000, IVP_RESP_OKAY);
    rd(IVP_ADDR_FUSE, 32'h0000_0019, IVP_RESP_OKAY);
    rd(IVP_ADDR_BASE, 32'h0000_0002, IVP_RESP_OKAY);
    rd(IVP_ADDR_STATUS, 32'h0000_0004, IVP_RESP_OKAY);
    rd(8'h10, 32'h0000_0000, IVP_RESP_SLVERR);
    wr(8'h14, 32'h0000_0001, IVP_RESP_SLVERR);
    wr(IVP_ADDR_STATUS, 32'hFFFF_FFFF, IVP_RESP_OKAY);
    port(1, "rst", 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      // pick the index first: the non-blocking update is not yet visible here
      e = (k == 0) ? 32'h0000_0000 : (k == 1) ? 32'h0000_0013 : $urandom % 21;
      want_idx <= e[4:0];
      port(1, "vec", 32'h0000_0002 + {e[30:0], 1'b0});
    end
    $display("test reset_and_app_slots done");
    e = $urandom & 32'h0000_00E0;
    wr(IVP_ADDR_GIC, e | 32'h0000_0002, IVP_RESP_OKAY);
    rd(IVP_ADDR_GIC, e, IVP_RESP_OKAY);
    chk("irq_en", {29'h0, e[7:5]}, {29'h0, ext_irq1_enable, ext_irq0_enable, ext_irq2_enable});
    wr(IVP_ADDR_GIC, e | 32'h0000_0001, IVP_RESP_OKAY);
    port(0, "irq", 32'h0000_0000);
    rd(IVP_ADDR_GIC, e | 32'h0000_0001, IVP_RESP_OKAY);
    port(6, "irq", 32'h0000_0001);
    rd(IVP_ADDR_GIC, e, IVP_RESP_OKAY);
    wr(IVP_ADDR_GIC, e | 32'h0000_0002, IVP_RESP_OKAY);
    rd(IVP_ADDR_GIC, e, IVP_RESP_OKAY);
    $display("test window_alone done");
    pace <= 4'h0;
    wr(IVP_ADDR_GIC, e | 32'h0000_0001, IVP_RESP_OKAY);
    wr(IVP_ADDR_GIC, e | 32'h0000_0002, IVP_RESP_OKAY);
    port(4, "irq", 32'h0000_0000);
    rd(IVP_ADDR_GIC, e | 32'h0000_0002, IVP_RESP_OKAY);
    rd(IVP_ADDR_BASE, 32'h0000_1C02, IVP_RESP_OKAY);
    pace <= 4'h2;
    port(8, "irq", 32'h0000_0001);
    want_idx <= 5'h00;
    port(1, "vec", 32'h0000_1C02);
    want_idx <= 5'h13;
    port(1, "vec", 32'h0000_1C28);
    port(0, "rst", 32'h0000_0000);
    $display("test move_to_boot done");
    app_side_boot_lock <= 1'b0;
    pc_base <= 13'($urandom % 32'h0000_1B00);
    port(1, "irq", 32'h0000_0000);
    pc_base <= 13'h1C40;
    port(1, "irq", 32'h0000_0001);
    app_side_boot_lock <= 1'b1;
    wr(IVP_ADDR_GIC, e | 32'h0000_0001, IVP_RESP_OKAY);
    wr(IVP_ADDR_GIC, e, IVP_RESP_OKAY);
    port(8, "irq", 32'h0000_0001);
    boot_side_boot_lock <= 1'b0;
    port(1, "irq", 32'h0000_0000);
    pc_base <= 13'h0200;
    port(1, "irq", 32'h0000_0001);
    boot_side_boot_lock <= 1'b1;
    $display("test lock_bits done");
    boot_reset_fuse <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      boot_size_fuses <= 2'(s);
      port(1, "rst", {19'h0, bb[s]});
    end
    rd(IVP_ADDR_BASE, 32'h0000_0002, IVP_RESP_OKAY);
    $display("test boot_reset done");
    close_out();
  end
endmodule
